// File: rtl/cbc_balance.sv
// Top of the two-cell balance controller: AHB-Lite settings, charge
// detection, measurement scheduling, threshold adaption and bypass drive.
// Assumes cell readings and sense voltage come from logic on hclk.
//
// Functional notes
// - While charging, bleed cells above threshold if cell spread exceeds minimum and the threshold is not raised.
// - While balancing, re-measure all cells once per interval and act on them.
// - Raise threshold by step if all cells above or highest exceeds by step.
// - No bypass load is ever enabled unless charging current is detected.
// - Each new charge cycle reloads the active threshold from start setting.
// - The active threshold rises at most once within one balance interval.
// - Each of the two cells has its own independent bypass enable.
// - Bypass is a weak pull-down on the cell's sense input pin.
// - Positive sense voltage means charging; negative means discharging.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module cbc_balance #(
  parameter int TICK_CYCLES = cbc_pkg::CBC_TICK_CYCLES  // Clock cycles in one interval unit.
) (
  input  wire logic              hclk,                 // Bus and core clock.
  input  wire logic              hresetn,              // Asynchronous reset, active low.
  input  wire logic              hsel,                 // AHB slave select.
  input  wire logic [7:0]        haddr,                // AHB byte address.
  input  wire logic [1:0]        htrans,               // AHB transfer type.
  input  wire logic              hwrite,               // AHB write.
  input  wire logic [2:0]        hsize,                // AHB size.
  input  wire logic [31:0]       hwdata,               // AHB write data.
  input  wire logic              hready,               // AHB ready in.
  output logic      [31:0]       hrdata,               // AHB read data.
  output logic                   hreadyout,            // AHB ready out.
  output logic                   hresp,                // AHB response.
  input  wire logic signed [15:0] sense_volt,          // Sense resistor voltage, high minus low.
  output logic                   meas_req,             // Pulse asking for new cell readings.
  input  wire logic              meas_done,            // Pulse: readings are valid.
  input  wire cbc_pkg::cbc_meas_t meas,                // Cell readings.
  output logic      [1:0]        cell_sense_input_out, // Pull-down level per cell pin.
  output logic      [1:0]        cell_sense_input_oe_n,// Pull-down enable per cell, low drives.
  output logic                   balance_assist_output // High while any cell is bled.
);
  import cbc_pkg::*;

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  cbc_cfg_t    cfg;
  cbc_stat_t   stat;
  cbc_state_t  state_r;
  cbc_state_t  state_nxt;
  logic        chg_r;
  logic        chg_prev_r;
  logic [15:0] thr_r;
  logic [15:0] thr_nxt;
  logic        raised_r;
  logic        raised_nxt;
  logic [1:0]  bal_r;
  logic [1:0]  bal_nxt;
  logic [15:0] cell_r [CBC_CELLS];
  logic [16:0] tick_r;
  logic [15:0] unit_r;
  logic        req_r;

  // Register slave holding the settings.
  cbc_ahb_regs u_regs (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .cfg       (cfg),
    .stat      (stat)
  );

  // Charge detection and the start of a charge cycle.
  wire chg_now    = (sense_volt > 16'sd0);
  wire chg_start  = chg_r & ~chg_prev_r;
  wire run        = chg_r & cfg.enable;

  // Interval timing: an interval of zero units is treated as one unit.
  wire        tick_end  = (tick_r == TICK_LAST);
  wire [15:0] unit_last = (cfg.interval == 16'h0000) ? 16'h0000 : cfg.interval - 16'h0001;
  wire        intv_end  = tick_end & (unit_r == unit_last);

  // Spread and threshold comparisons on the latest readings.
  wire [15:0] hi_cell   = (cell_r[0] > cell_r[1]) ? cell_r[0] : cell_r[1];
  wire [15:0] lo_cell   = (cell_r[0] > cell_r[1]) ? cell_r[1] : cell_r[0];
  wire [15:0] spread    = hi_cell - lo_cell;
  wire [16:0] thr_plus  = {1'b0, thr_r} + {1'b0, cfg.step};
  wire        all_above = (cell_r[0] > thr_r) & (cell_r[1] > thr_r);
  wire        hi_over   = ({1'b0, hi_cell} >= thr_plus);
  wire        want_raise = (all_above | hi_over) & ~thr_plus[16];
  wire        imbalanced = (spread > cfg.min_imb);

  // Latch the charge polarity and keep last cycle's value for edge finding.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_r      <= 1'b0;
      chg_prev_r <= 1'b0;
    end else begin
      chg_r      <= chg_now;
      chg_prev_r <= chg_r;
    end
  end

  // Capture each new set of readings.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_r[0] <= 16'h0000;
      cell_r[1] <= 16'h0000;
    end else if (meas_done && state_r == CBC_S_REQ) begin
      cell_r[0] <= meas.cell1;
      cell_r[1] <= meas.cell2;
    end
  end

  // Interval counter runs only in the waiting state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_r <= 17'h0_0000;
      unit_r <= 16'h0000;
    end else if (state_r != CBC_S_WAIT) begin
      tick_r <= 17'h0_0000;
      unit_r <= 16'h0000;
    end else if (tick_end) begin
      tick_r <= 17'h0_0000;
      unit_r <= unit_r + 16'h0001;
    end else begin
      tick_r <= tick_r + 17'h0_0001;
    end
  end

  // Engine: request readings, evaluate once, then wait out the interval.
  always_comb begin
    state_nxt  = state_r;
    thr_nxt    = thr_r;
    raised_nxt = raised_r;
    bal_nxt    = bal_r;
    case (state_r)
      CBC_S_IDLE: begin
        raised_nxt = 1'b0;
        if (run) begin
          state_nxt = CBC_S_REQ;
        end
      end
      CBC_S_REQ: begin
        if (meas_done) begin
          state_nxt = CBC_S_EVAL;
        end
      end
      CBC_S_EVAL: begin
        state_nxt = CBC_S_WAIT;
        if (want_raise && !raised_r) begin
          thr_nxt    = thr_plus[15:0];
          raised_nxt = 1'b1;
          bal_nxt    = 2'b00;
        end else if (imbalanced) begin
          bal_nxt[0] = (cell_r[0] > thr_r);
          bal_nxt[1] = (cell_r[1] > thr_r);
        end else begin
          bal_nxt = 2'b00;
        end
      end
      CBC_S_WAIT: begin
        if (intv_end) begin
          state_nxt  = CBC_S_REQ;
          raised_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = CBC_S_IDLE;
      end
    endcase
    // Losing charge current or the enable stops balancing at once.
    if (!run) begin
      state_nxt = CBC_S_IDLE;
      bal_nxt   = 2'b00;
    end
    // A new charge cycle starts from the programmed threshold.
    if (chg_start) begin
      thr_nxt    = cfg.start_thr;
      raised_nxt = 1'b0;
    end
  end

  // Engine state flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= CBC_S_IDLE;
      thr_r    <= CBC_RST_START;
      raised_r <= 1'b0;
      bal_r    <= 2'b00;
    end else begin
      state_r  <= state_nxt;
      thr_r    <= thr_nxt;
      raised_r <= raised_nxt;
      bal_r    <= bal_nxt;
    end
  end

  // One-cycle measurement request on entry to the request state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= 1'b0;
    end else begin
      req_r <= (state_nxt == CBC_S_REQ) & (state_r != CBC_S_REQ);
    end
  end

  assign meas_req = req_r;

  // Pull-down drive per cell pin, also gated by live charge detection.
  genvar gi;
  generate
    for (gi = 0; gi < CBC_CELLS; gi++) begin : g_cell
      assign cell_sense_input_out[gi]  = 1'b0;
      assign cell_sense_input_oe_n[gi] = ~(bal_r[gi] & chg_r);
    end
  endgenerate

  assign balance_assist_output = |(bal_r & {2{chg_r}});

  // Read-back state.
  assign stat.charging = chg_r;
  assign stat.bypass   = bal_r & {2{chg_r}};
  assign stat.raised   = raised_r;
  assign stat.active   = (state_r != CBC_S_IDLE);
  assign stat.thr      = thr_r;
  assign stat.cell1    = cell_r[0];
  assign stat.cell2    = cell_r[1];

endmodule // cbc_balance

// File: rtl/cbc_pkg.sv
// Package for the two-cell balance controller: register map, field layout,
// reset values, timing constants and the carrier structs.
// Assumes a 125 MHz bus clock and 16-bit cell readings in millivolts.
package cbc_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] CBC_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CBC_OFF_START    = 8'h04;
  localparam logic [7:0] CBC_OFF_MIN_IMB  = 8'h08;
  localparam logic [7:0] CBC_OFF_INTERVAL = 8'h0C;
  localparam logic [7:0] CBC_OFF_STEP     = 8'h10;
  localparam logic [7:0] CBC_OFF_STATUS   = 8'h14;
  localparam logic [7:0] CBC_OFF_THR      = 8'h18;
  localparam logic [7:0] CBC_OFF_CELLS    = 8'h1C;

  // Field positions.
  localparam int CBC_CTRL_EN_BIT    = 0;
  localparam int CBC_ST_CHG_BIT     = 0;
  localparam int CBC_ST_BYP_LSB     = 1;
  localparam int CBC_ST_RAISED_BIT  = 3;
  localparam int CBC_ST_ACTIVE_BIT  = 4;

  // Reset values of the writable settings.
  localparam logic        CBC_RST_EN       = 1'b1;
  localparam logic [15:0] CBC_RST_START    = 16'h0F3C;
  localparam logic [15:0] CBC_RST_MIN_IMB  = 16'h0028;
  localparam logic [15:0] CBC_RST_INTERVAL = 16'h0014;
  localparam logic [15:0] CBC_RST_STEP     = 16'h0014;

  // Number of series cells.
  localparam int CBC_CELLS = 2;

  // Interval unit: one millisecond of the 125 MHz clock.
  localparam int CBC_TICK_US     = 1000;
  localparam int CBC_CLK_MHZ     = 125;
  localparam int CBC_TICK_CYCLES = CBC_TICK_US * CBC_CLK_MHZ;

  // Settings that software programs.
  typedef struct packed {
    logic        enable;
    logic [15:0] start_thr;
    logic [15:0] min_imb;
    logic [15:0] interval;
    logic [15:0] step;
  } cbc_cfg_t;

  // State that software reads back.
  typedef struct packed {
    logic        charging;
    logic [1:0]  bypass;
    logic        raised;
    logic        active;
    logic [15:0] thr;
    logic [15:0] cell1;
    logic [15:0] cell2;
  } cbc_stat_t;

  // One set of cell measurements.
  typedef struct packed {
    logic [15:0] cell2;
    logic [15:0] cell1;
  } cbc_meas_t;

  // Balance engine states.
  typedef enum logic [1:0] {
    CBC_S_IDLE = 2'b00,
    CBC_S_REQ  = 2'b01,
    CBC_S_EVAL = 2'b10,
    CBC_S_WAIT = 2'b11
  } cbc_state_t;

endpackage

// File: rtl/cbc_ahb_regs.sv
// AHB-Lite register slave for the balance controller.
// Assumes a single master; zero wait states, always OKAY.
`timescale 1ns/1ps
module cbc_ahb_regs (
  input  wire logic              hclk,       // Bus clock.
  input  wire logic              hresetn,    // Asynchronous reset, active low.
  input  wire logic              hsel,       // Slave select.
  input  wire logic [7:0]        haddr,      // Byte address.
  input  wire logic [1:0]        htrans,     // Transfer type.
  input  wire logic              hwrite,     // Write when high.
  input  wire logic [2:0]        hsize,      // Transfer size.
  input  wire logic [31:0]       hwdata,     // Write data.
  input  wire logic              hready,     // Bus ready.
  output logic      [31:0]       hrdata,     // Read data.
  output logic                   hreadyout,  // Slave ready.
  output logic                   hresp,      // Response.
  output cbc_pkg::cbc_cfg_t      cfg,        // Programmed settings.
  input  wire cbc_pkg::cbc_stat_t stat       // Engine state.
);
  import cbc_pkg::*;

  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  cbc_cfg_t   cfg_r;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  wire        acc_valid = hsel & htrans[1] & hready;
  wire        unused_size = |hsize;

  // Status word built from the engine flags.
  assign status_word = {27'h000_0000, stat.active, stat.raised, stat.bypass, stat.charging};

  // Read selection; unmapped offsets read as zero.
  assign rd_mux = (haddr == CBC_OFF_CTRL)     ? {31'h0000_0000, cfg_r.enable} :
                  (haddr == CBC_OFF_START)    ? {16'h0000, cfg_r.start_thr} :
                  (haddr == CBC_OFF_MIN_IMB)  ? {16'h0000, cfg_r.min_imb} :
                  (haddr == CBC_OFF_INTERVAL) ? {16'h0000, cfg_r.interval} :
                  (haddr == CBC_OFF_STEP)     ? {16'h0000, cfg_r.step} :
                  (haddr == CBC_OFF_STATUS)   ? status_word :
                  (haddr == CBC_OFF_THR)      ? {16'h0000, stat.thr} :
                  (haddr == CBC_OFF_CELLS)    ? {stat.cell2, stat.cell1} : 32'h0000_0000;

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = unused_size & 1'b0;
  assign cfg       = cfg_r;

  // Address phase capture; read data is ready for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= acc_valid & hwrite;
      wr_addr_r <= haddr;
      if (acc_valid && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Data phase writes to the settings.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r.enable    <= CBC_RST_EN;
      cfg_r.start_thr <= CBC_RST_START;
      cfg_r.min_imb   <= CBC_RST_MIN_IMB;
      cfg_r.interval  <= CBC_RST_INTERVAL;
      cfg_r.step      <= CBC_RST_STEP;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        CBC_OFF_CTRL:     cfg_r.enable    <= hwdata[CBC_CTRL_EN_BIT];
        CBC_OFF_START:    cfg_r.start_thr <= hwdata[15:0];
        CBC_OFF_MIN_IMB:  cfg_r.min_imb   <= hwdata[15:0];
        CBC_OFF_INTERVAL: cfg_r.interval  <= hwdata[15:0];
        CBC_OFF_STEP:     cfg_r.step      <= hwdata[15:0];
        default: ;
      endcase
    end
  end

endmodule // cbc_ahb_regs

// File: tb/cbc_balance_assertions.sv
// Concurrent checks on the ports of the balance controller top.
// Assumes one clock, hclk, and the asynchronous active-low reset hresetn.
`timescale 1ns/1ps
module cbc_balance_chk (
  input wire logic              hclk,                  // Core clock.
  input wire logic              hresetn,               // Reset, active low.
  input wire logic              hreadyout,             // Slave ready.
  input wire logic              hresp,                 // Slave response.
  input wire logic signed [15:0] sense_volt,           // Sense voltage.
  input wire logic              meas_req,              // Reading request.
  input wire logic              meas_done,             // Reading valid.
  input wire logic [1:0]        cell_sense_input_out,  // Pin level.
  input wire logic [1:0]        cell_sense_input_oe_n, // Pin enable, low drives.
  input wire logic              balance_assist_output  // Any bypass on.
);
  // All checks share the one clock and reset.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Steps of the charge detection that the checks are built from.
  sequence no_charge3;
    (sense_volt <= 0) [*3];
  endsequence
  sequence charge_rise;
    $rose(sense_volt > 0);
  endsequence

  nobyp_idle_a: assert property ((sense_volt <= 0) |=> cell_sense_input_oe_n == 2'b11)
    else $error("bypass on without charge current");
  assist_drop_a: assert property ((sense_volt <= 0) |=> !balance_assist_output)
    else $error("assist output stayed on after charge loss");
  assist_match_a: assert property (balance_assist_output == (cell_sense_input_oe_n != 2'b11))
    else $error("assist output disagrees with bypass pins");
  pull_low_a: assert property (cell_sense_input_out == 2'b00)
    else $error("pin level is not a pull-down");
  req_pulse_a: assert property (meas_req |=> !meas_req)
    else $error("reading request longer than one cycle");
  req_quiet_a: assert property (no_charge3 |=> !meas_req)
    else $error("reading request without charge");
  byp_cause_a: assert property (((~cell_sense_input_oe_n & $past(cell_sense_input_oe_n)) != 2'b00)
    |-> $past(meas_done, 2))
    else $error("bypass turned on without a fresh reading");
  meas_start_a: assert property (charge_rise |-> ##[1:4] meas_req)
    else $error("no reading request at charge start");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not OKAY");
endmodule // cbc_balance_chk

// File: tb/cbc_meas_model.sv
// Behavioural cell measurement front end facing the balance controller.
// Assumes a request pulse on hclk; answers DELAY+1 cycles later.
`timescale 1ns/1ps
module cbc_meas_model #(
  parameter int DELAY = 4  // Answer latency in cycles.
) (
  input  wire logic        hclk,      // Clock.
  input  wire logic        hresetn,   // Reset, active low.
  input  wire logic        meas_req,  // Reading request pulse.
  input  wire logic [15:0] cell1_mv,  // Voltage of cell 1.
  input  wire logic [15:0] cell2_mv,  // Voltage of cell 2.
  output logic             meas_done, // Reading valid pulse.
  output cbc_pkg::cbc_meas_t meas     // Readings.
);
  import cbc_pkg::*;
  logic [7:0] cnt_r;

  // Readings are only valid with the pulse; otherwise the bus toggles.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r     <= 8'h00;
      meas_done <= 1'b0;
      meas      <= '0;
    end else begin
      meas_done <= (cnt_r == 8'h01);
      if (meas_req) cnt_r <= 8'(DELAY);
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01) meas <= '{cell2: cell2_mv, cell1: cell1_mv};
      else meas <= ~meas;
    end
  end
endmodule // cbc_meas_model

// File: tb/tb_top.sv
// Self-checking bench of the balance controller over AHB-Lite.
// Assumes the measurement model answers every request while charging.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import cbc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_req, meas_done, assist;
  logic [7:0]  haddr;
  logic [1:0]  htrans, pin_lvl, pin_oe_n;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic signed [15:0] sense_volt;
  logic [15:0] c1, c2;
  cbc_meas_t   meas;
  int          fails, n_compared, cycles;
  logic [7:0]  ra [7] = '{CBC_OFF_CTRL, CBC_OFF_START, CBC_OFF_MIN_IMB, CBC_OFF_INTERVAL, CBC_OFF_STEP,
                          CBC_OFF_THR, 8'h20};
  logic [15:0] rv [7] = '{16'h0001, 16'h0F3C, 16'h0028, 16'h0014, 16'h0014, 16'h0F3C, 16'h0000};

  cbc_balance #(.TICK_CYCLES(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sense_volt(sense_volt), .meas_req(meas_req),
    .meas_done(meas_done), .meas(meas), .cell_sense_input_out(pin_lvl),
    .cell_sense_input_oe_n(pin_oe_n), .balance_assist_output(assist));
  cbc_meas_model #(.DELAY(4)) model (.hclk(hclk), .hresetn(hresetn), .meas_req(meas_req),
    .cell1_mv(c1), .cell2_mv(c2), .meas_done(meas_done), .meas(meas));

  // Clock of 8 ns and a cycle ceiling that cuts a hang short.
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // One single-word AHB-Lite transfer; returns read data of the data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10; hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // Waits for n answered readings, then lets the evaluation land.
  task automatic wait_meas(input int n);
    repeat (n) do @(posedge hclk); while (meas_done !== 1'b1);
    repeat (3) @(posedge hclk);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: settings, bleeding, threshold steps, charge cycles.
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = 32'h0000_0000; sense_volt = 16'hFFFF; c1 = 16'h0000; c2 = 16'h0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ra[i], 32'h0000_0000, q);
      `CHK("reset value", rv[i], q[15:0])
    end
    bus(1'b1, CBC_OFF_THR, 32'h0000_FFFF, q);
    bus(1'b0, CBC_OFF_THR, 32'h0000_0000, q);
    `CHK("threshold read-only", 32'h0000_0F3C, q)
    bus(1'b1, CBC_OFF_START, 32'h0000_0FA0, q);
    bus(1'b1, CBC_OFF_MIN_IMB, 32'h0000_0030, q);
    bus(1'b1, CBC_OFF_INTERVAL, 32'h0000_0001, q);
    c1 <= 16'h0FAA; c2 <= 16'h0F6E; sense_volt <= 16'h0005;
    wait_meas(1);
    `CHK("bleed cell 1", 2'b10, pin_oe_n)
    `CHK("assist on", 1'b1, assist)
    bus(1'b0, CBC_OFF_STATUS, 32'h0000_0000, q);
    `CHK("status", 5'h13, q[4:0])
    c2 <= 16'h0F82;
    wait_meas(2);
    `CHK("small spread", 2'b11, pin_oe_n)
    c1 <= 16'h0F6E; c2 <= 16'h0FAA;
    wait_meas(2);
    `CHK("bleed cell 2", 2'b01, pin_oe_n)
    sense_volt <= 16'hFFFB;
    repeat (3) @(posedge hclk);
    `CHK("discharge pins", 2'b11, pin_oe_n)
    `CHK("discharge assist", 1'b0, assist)
    bus(1'b0, CBC_OFF_STATUS, 32'h0000_0000, q);
    `CHK("not charging", 1'b0, q[0])
    c1 <= 16'h0FD2; c2 <= 16'h0FBE; sense_volt <= 16'h0001;
    wait_meas(1);
    bus(1'b0, CBC_OFF_THR, 32'h0000_0000, q);
    `CHK("raised once", 32'h0000_0FB4, q)
    `CHK("no bleed on raise", 2'b11, pin_oe_n)
    bus(1'b0, CBC_OFF_STATUS, 32'h0000_0000, q);
    `CHK("raised flag", 5'h19, q[4:0])
    bus(1'b0, CBC_OFF_CELLS, 32'h0000_0000, q);
    `CHK("cell readings", 32'h0FBE_0FD2, q)
    wait_meas(1);
    bus(1'b0, CBC_OFF_THR, 32'h0000_0000, q);
    `CHK("one step per interval", 32'h0000_0FC8, q)
    sense_volt <= 16'hFFFF; c1 <= 16'h0FB9; c2 <= 16'h0F96;
    repeat (3) @(posedge hclk);
    sense_volt <= 16'h0001;
    wait_meas(1);
    bus(1'b0, CBC_OFF_THR, 32'h0000_0000, q);
    `CHK("reload then window raise", 32'h0000_0FB4, q)
    give_verdict();
  end
endmodule // tb_top

bind cbc_balance cbc_balance_chk chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .sense_volt(sense_volt), .meas_req(meas_req), .meas_done(meas_done),
  .cell_sense_input_out(cell_sense_input_out), .cell_sense_input_oe_n(cell_sense_input_oe_n),
  .balance_assist_output(balance_assist_output));
